// ===== common/nfh_pkg.sv
/*
  Package for the NAND flash host controller: array geometry, address
  cycle layout, command codes, pin timing counts and controller states.
  Assumes a 125 MHz system clock.
*/
package nfh_pkg;
  // Bus and array geometry
  localparam int IO_WIDTH = 8;
  localparam int BLOCK_COUNT = 1024;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int MAIN_BYTES = 2048;
  localparam int SPARE_BYTES = 64;
  localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
  localparam int COL_WIDTH = 12;
  localparam int ROW_WIDTH = 16;
  localparam int ADDR_CYCLES = 4;
  localparam logic [2:0] ADDR_CYC_LAST = 3'h3;
  // Second address cycle: column high bits on low four lines
  localparam int COL_HI_LSB = 8;
  localparam int COL_HI_WIDTH = 4;
  localparam logic [3:0] UNUSED_LINES = 4'h0;
  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  // Pin timing, in ns, and derived cycle counts (minimum times round up)
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_LOW_NS = 25;
  localparam int STROBE_HIGH_NS = 15;
  localparam int READ_ACCESS_DELAY_NS = 25;
  localparam int SETUP_NS = 16;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read sample after access delay plus two synchroniser stages
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wait after confirm before ready_busy_n is trusted
  localparam int BUSY_WAIT_NS = 100;
  localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 8;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_CMD1 = 8'b0000_0010,
    ST_ADDR = 8'b0000_0100,
    ST_CMD2 = 8'b0000_1000,
    ST_WAIT = 8'b0001_0000,
    ST_BUSY = 8'b0010_0000,
    ST_READ = 8'b0100_0000,
    ST_DONE = 8'b1000_0000
  } nfh_state_type;
endpackage : nfh_pkg

// ===== rtl/nfh_host.sv
/*
  NAND flash host controller: runs a page read (setup command, four
  address cycles, confirm command), waits for ready, then reads bytes
  out with read strobe pulses and hands each byte to the user.
  Assumes an x8 device on the pins and a pull-up on ready_busy_n.
*/
`timescale 1ns/100ps
// Behaviour
// - Command, address, data set on io_bus before the write strobe rises.
// - Address latch high at write strobe rise stores address bytes.
// - Command latch high at write strobe rise stores command bytes.
// - One shared 8-bit io_bus carries commands, addresses and data.
// - Column bits 0-7 in cycle one, 8-11 on low lines of cycle two.
// - Row bits 12-27 sent in cycles three and four, ascending.
// - Upper four lines of the second address cycle driven low.
// - Page read is 00h, four addresses, 30h, then busy.
module nfh_host #(
  parameter int MAX_LEN = nfh_pkg::PAGE_BYTES
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // User request
  input wire logic REQ_VALID,
  input wire logic [nfh_pkg::ROW_WIDTH-1:0] REQ_ROW,
  input wire logic [nfh_pkg::COL_WIDTH-1:0] REQ_COL,
  input wire logic [nfh_pkg::COL_WIDTH:0] REQ_LEN,
  output logic REQ_READY,
  // User read data
  output logic RD_VALID,
  output logic [nfh_pkg::IO_WIDTH-1:0] RD_DATA,
  output logic RD_DONE,
  // Flash pins
  output logic CHIP_SEL_N,
  output logic CMD_LATCH,
  output logic ADDR_LATCH,
  output logic WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic WRITE_PROT_N,
  input wire logic [nfh_pkg::IO_WIDTH-1:0] IO_BUS_IN,
  output logic [nfh_pkg::IO_WIDTH-1:0] IO_BUS_OUT,
  output logic IO_BUS_OE_N,
  input wire logic READY_BUSY_N
);
  import nfh_pkg::*;

  nfh_state_type state_q, state_d;
  logic [COL_WIDTH-1:0] col_q, col_d;
  logic [ROW_WIDTH-1:0] row_q, row_d;
  logic [COL_WIDTH:0] left_q, left_d;
  logic [2:0] acyc_q, acyc_d;
  logic [IO_WIDTH-1:0] bus_q, bus_d;
  logic oe_n_q, oe_n_d, cs_n_q, cs_n_d, cle_q, cle_d, ale_q, ale_d;
  logic rdy_q, rdy_d, rvalid_q, rvalid_d, rdone_q, rdone_d;
  logic [IO_WIDTH-1:0] rdata_q, rdata_d;
  logic [TIMER_WIDTH-1:0] wait_q, wait_d;
  logic [IO_WIDTH-1:0] io_s1_q, io_s2_q;
  logic rb_s1_q, rb_s2_q;
  logic wr_go, rd_go, wr_low, wr_end, rd_low, rd_mid, rd_end;

  // Pin inputs pass two flops before use
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      io_s1_q <= '0;
      io_s2_q <= '0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      io_s1_q <= IO_BUS_IN;
      io_s2_q <= io_s1_q;
      rb_s1_q <= READY_BUSY_N;
      rb_s2_q <= rb_s1_q;
    end
  end

  // Write strobe: high phase lengthened by the data and latch setup count
  nfh_strobe #(.LOW_CYC(STROBE_LOW_CYC), .HIGH_CYC(STROBE_HIGH_CYC + SETUP_CYC)) u_wr (
    .clk(SYS_CLK),
    .srst(SRST),
    .start(wr_go),
    .strobe_low(wr_low),
    .low_done(),
    .cycle_done(wr_end)
  );

  // Read strobe: low long enough to cover access delay and synchronisers
  nfh_strobe #(.LOW_CYC(READ_ACCESS_CYC), .HIGH_CYC(STROBE_HIGH_CYC)) u_rd (
    .clk(SYS_CLK),
    .srst(SRST),
    .start(rd_go),
    .strobe_low(rd_low),
    .low_done(rd_mid),
    .cycle_done(rd_end)
  );

  always_comb begin
    state_d = state_q;
    col_d = col_q;
    row_d = row_q;
    left_d = left_q;
    acyc_d = acyc_q;
    bus_d = bus_q;
    oe_n_d = oe_n_q;
    cs_n_d = cs_n_q;
    cle_d = 1'b0;
    ale_d = 1'b0;
    rdy_d = 1'b0;
    rvalid_d = 1'b0;
    rdone_d = 1'b0;
    rdata_d = rdata_q;
    wait_d = wait_q;
    wr_go = 1'b0;
    rd_go = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cs_n_d = 1'b1;
        oe_n_d = 1'b1;
        rdy_d = 1'b1;
        if (REQ_VALID && rdy_q) begin
          rdy_d = 1'b0;
          row_d = REQ_ROW;
          col_d = REQ_COL;
          left_d = (REQ_LEN == '0) ? (COL_WIDTH+1)'(1) : REQ_LEN;
          cs_n_d = 1'b0;
          oe_n_d = 1'b0;
          bus_d = CMD_READ_SETUP;
          state_d = ST_CMD1;
        end
      end
      ST_CMD1: begin
        cle_d = 1'b1;
        wr_go = 1'b1;
        if (wr_end) begin
          cle_d = 1'b0;
          acyc_d = '0;
          bus_d = col_q[7:0];
          state_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        ale_d = 1'b1;
        wr_go = 1'b1;
        if (wr_end) begin
          acyc_d = acyc_q + 3'h1;
          case (acyc_q)
            3'h0: bus_d = {UNUSED_LINES, col_q[COL_HI_LSB +: COL_HI_WIDTH]};
            3'h1: bus_d = row_q[7:0];
            3'h2: bus_d = row_q[15:8];
            default: bus_d = CMD_READ_CONFIRM;
          endcase
          if (acyc_q == ADDR_CYC_LAST) begin
            ale_d = 1'b0;
            bus_d = CMD_READ_CONFIRM;
            state_d = ST_CMD2;
          end
        end
      end
      ST_CMD2: begin
        cle_d = 1'b1;
        wr_go = 1'b1;
        if (wr_end) begin
          cle_d = 1'b0;
          oe_n_d = 1'b1; // Hand the bus to the device
          wait_d = TIMER_WIDTH'(BUSY_WAIT_CYC);
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Busy may take a while to assert; do not trust ready before that
        if (wait_q != '0) begin
          wait_d = wait_q - TIMER_WIDTH'(1);
        end else begin
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (rb_s2_q) begin
          state_d = ST_READ;
        end
      end
      ST_READ: begin
        rd_go = (left_q != '0);
        if (rd_mid) begin
          rdata_d = io_s2_q;
          rvalid_d = 1'b1;
        end
        if (rd_end) begin
          left_d = left_q - (COL_WIDTH+1)'(1);
          col_d = col_q + COL_WIDTH'(1);
          // Sequential read stops at the last spare byte of the page
          if (left_q == (COL_WIDTH+1)'(1) || col_q == COL_WIDTH'(MAX_LEN - 1)) begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        rdone_d = 1'b1;
        cs_n_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      col_q <= '0;
      row_q <= '0;
      left_q <= '0;
      acyc_q <= '0;
      bus_q <= '0;
      oe_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdone_q <= 1'b0;
      rdata_q <= '0;
      wait_q <= '0;
    end else begin
      state_q <= state_d;
      col_q <= col_d;
      row_q <= row_d;
      left_q <= left_d;
      acyc_q <= acyc_d;
      bus_q <= bus_d;
      oe_n_q <= oe_n_d;
      cs_n_q <= cs_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      rdy_q <= rdy_d;
      rvalid_q <= rvalid_d;
      rdone_q <= rdone_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  // Strobe pins registered so every output comes from a flop
  logic wr_n_q, rd_n_q, wp_n_q;
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wp_n_q <= 1'b0;
    end else begin
      wr_n_q <= ~wr_low;
      rd_n_q <= ~rd_low;
      wp_n_q <= 1'b0;
    end
  end

  assign CHIP_SEL_N = cs_n_q;
  assign CMD_LATCH = cle_q;
  assign ADDR_LATCH = ale_q;
  assign WRITE_STROBE_N = wr_n_q;
  assign READ_STROBE_N = rd_n_q;
  // Read-only controller: program and erase stay blocked
  assign WRITE_PROT_N = wp_n_q;
  assign IO_BUS_OUT = bus_q;
  assign IO_BUS_OE_N = oe_n_q;
  assign REQ_READY = rdy_q;
  assign RD_VALID = rvalid_q;
  assign RD_DATA = rdata_q;
  assign RD_DONE = rdone_q;
endmodule : nfh_host

// ===== rtl/nfh_strobe.sv
/*
  Strobe timer for the NAND host: counts a low phase and a high phase of
  one write or read strobe and pulses the end of each phase.
  Assumes start may stay high; a new strobe begins only once idle.
*/
`timescale 1ns/100ps
module nfh_strobe #(
  parameter int LOW_CYC = 4,
  parameter int HIGH_CYC = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Control
  input wire logic start,
  output logic strobe_low,
  output logic low_done,
  output logic cycle_done
);
  import nfh_pkg::*;
  logic [TIMER_WIDTH-1:0] cnt_q, cnt_d;
  logic low_q, low_d;
  logic busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    low_d = low_q;
    busy_d = busy_q;
    low_done = 1'b0;
    cycle_done = 1'b0;
    if (start && !busy_q) begin
      busy_d = 1'b1;
      low_d = 1'b1;
      cnt_d = TIMER_WIDTH'(LOW_CYC - 1);
    end else if (busy_q) begin
      if (cnt_q != '0) begin
        cnt_d = cnt_q - TIMER_WIDTH'(1);
      end else if (low_q) begin
        low_d = 1'b0;
        low_done = 1'b1;
        cnt_d = TIMER_WIDTH'(HIGH_CYC - 1);
      end else begin
        busy_d = 1'b0;
        cycle_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      low_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      low_q <= low_d;
      busy_q <= busy_d;
    end
  end

  assign strobe_low = low_q;
endmodule : nfh_strobe

// ===== tb/nfh_flash_model.sv
/*
  Behavioural x8 NAND flash, page read only.
  Assumes the bench adds the pull-up on the busy line.
*/
`timescale 1ns/100ps
module nfh_flash_model (
  // Control pins
  input wire logic chip_sel_n,
  input wire logic cmd_latch,
  input wire logic addr_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_prot_n,
  // Bus and status
  input wire logic [7:0] host_out,
  input wire logic host_oe_n,
  output logic [7:0] io_bus,
  output logic pull_low,
  // Bench knob
  input wire logic [15:0] busy_ns
);
  localparam int READ_ACCESS_DELAY = 20;
  logic [7:0] adr [4];
  logic [7:0] last;
  logic [15:0] row;
  logic [11:0] col;
  logic drive;
  int na;
  initial begin
    pull_low = 1'b0;
    drive = 1'b0;
    last = 8'h5a;
    na = 4;
  end
  // Released bus shows the inverse of the last byte, never a held value
  assign io_bus = !host_oe_n ? host_out : (drive && !chip_sel_n ? last : ~last);
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && cmd_latch) begin
      if (io_bus == 8'h00) na = 0;
      if (io_bus == 8'h30 && na == 4) begin
        col = {adr[1][3:0], adr[0]};
        row = {adr[3], adr[2]};
        pull_low = 1'b1;
        pull_low <= #(busy_ns) 1'b0;
      end
      // No program or erase is modelled, so write_prot_n is never needed
    end else if (!chip_sel_n && addr_latch && na < 4) begin
      adr[na] = io_bus;
      na = na + 1;
    end
  end
  always @(negedge read_strobe_n) begin
    if (!chip_sel_n && !pull_low) begin
      drive = 1'b0;
      #(READ_ACCESS_DELAY);
      last = row[7:0] ^ row[15:8] ^ col[7:0] ^ {4'h0, col[11:8]};
      drive = 1'b1;
    end
  end
  always @(posedge read_strobe_n) begin
    drive = 1'b0;
    if (!chip_sel_n) col = col + 12'h001;
  end
endmodule : nfh_flash_model

// ===== tb/nfh_host_chk.sv
/*
  Pin and handshake assertions for the NAND flash host.
  Assumes the bench resolves ready_busy_n with a pull-up.
*/
`timescale 1ns/100ps
module nfh_host_chk (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // Watched ports
  input wire logic REQ_READY,
  input wire logic CHIP_SEL_N,
  input wire logic CMD_LATCH,
  input wire logic ADDR_LATCH,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_PROT_N,
  input wire logic [7:0] IO_BUS_OUT,
  input wire logic IO_BUS_OE_N,
  input wire logic READY_BUSY_N
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  logic we_q;
  logic we_rise;
  logic [2:0] na_q;
  logic [2:0] na_d;
  assign we_rise = WRITE_STROBE_N && !we_q;
  always_comb begin
    na_d = na_q;
    if (we_rise && CMD_LATCH) na_d = 3'h0;
    else if (we_rise && ADDR_LATCH) na_d = na_q + 3'h1;
  end
  always_ff @(posedge SYS_CLK) begin
    we_q <= WRITE_STROBE_N;
    na_q <= SRST ? 3'h0 : na_d;
  end
  sequence s_addr2; we_rise && ADDR_LATCH && na_q == 3'h1; endsequence
  sequence s_confirm; we_rise && CMD_LATCH && IO_BUS_OUT == 8'h30; endsequence
  a_latch_excl: assert property (!(CMD_LATCH && ADDR_LATCH))
    else $error("both latches high");
  a_wp_low: assert property (!WRITE_PROT_N)
    else $error("write protect released");
  a_idle_deselect: assert property (REQ_READY |-> CHIP_SEL_N)
    else $error("selected while idle");
  a_strobe_sel: assert property (!WRITE_STROBE_N || !READ_STROBE_N |-> !CHIP_SEL_N)
    else $error("strobe while deselected");
  a_write_drive: assert property (!WRITE_STROBE_N |-> !IO_BUS_OE_N && READ_STROBE_N)
    else $error("bus not driven in write");
  a_read_release: assert property (!READ_STROBE_N |-> IO_BUS_OE_N && WRITE_STROBE_N)
    else $error("bus driven in read");
  a_write_hold: assert property ($rose(WRITE_STROBE_N) |->
    $stable(IO_BUS_OUT) && $stable(CMD_LATCH) && $stable(ADDR_LATCH))
    else $error("bus moved at strobe rise");
  a_upper_low: assert property (s_addr2 |-> IO_BUS_OUT[7:4] == 4'h0)
    else $error("upper lines not low");
  a_addr_count: assert property (s_confirm |-> na_q == 3'h4)
    else $error("confirm without four addresses");
  a_read_ready: assert property ($fell(READ_STROBE_N) |->
    READY_BUSY_N && $past(READY_BUSY_N, 2))
    else $error("read strobe while busy");
endmodule : nfh_host_chk

bind nfh_host nfh_host_chk u_chk (.SYS_CLK, .SRST, .REQ_READY, .CHIP_SEL_N, .CMD_LATCH,
  .ADDR_LATCH, .WRITE_STROBE_N, .READ_STROBE_N, .WRITE_PROT_N, .IO_BUS_OUT, .IO_BUS_OE_N,
  .READY_BUSY_N);

// ===== tb/test_nand_flash_bus_interface.sv
/*
  Self-checking bench for the NAND flash host.
  Assumes the behavioural flash model and a pull-up on the busy line.
*/
`timescale 1ns/100ps
module test_nand_flash_bus_interface;
  import nfh_pkg::*;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic REQ_VALID = 1'b0;
  logic [ROW_WIDTH-1:0] REQ_ROW = '0;
  logic [COL_WIDTH-1:0] REQ_COL = '0;
  logic [COL_WIDTH:0] REQ_LEN = '0;
  logic REQ_READY, RD_VALID, RD_DONE, CHIP_SEL_N, CMD_LATCH, ADDR_LATCH;
  logic WRITE_STROBE_N, READ_STROBE_N, WRITE_PROT_N, IO_BUS_OE_N, pull_low;
  logic [7:0] RD_DATA, IO_BUS_IN, IO_BUS_OUT;
  logic [15:0] busy_ns = 16'h0190;
  wire READY_BUSY_N = !pull_low;
  int n_errors = 0;
  int comparisons = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  nfh_host uut (.SYS_CLK, .SRST, .REQ_VALID, .REQ_ROW, .REQ_COL, .REQ_LEN, .REQ_READY,
    .RD_VALID, .RD_DATA, .RD_DONE, .CHIP_SEL_N, .CMD_LATCH, .ADDR_LATCH, .WRITE_STROBE_N,
    .READ_STROBE_N, .WRITE_PROT_N, .IO_BUS_IN, .IO_BUS_OUT, .IO_BUS_OE_N, .READY_BUSY_N);
  nfh_flash_model u_flash (.chip_sel_n(CHIP_SEL_N), .cmd_latch(CMD_LATCH),
    .addr_latch(ADDR_LATCH), .write_strobe_n(WRITE_STROBE_N), .read_strobe_n(READ_STROBE_N),
    .write_prot_n(WRITE_PROT_N), .host_out(IO_BUS_OUT), .host_oe_n(IO_BUS_OE_N),
    .io_bus(IO_BUS_IN), .pull_low(pull_low), .busy_ns(busy_ns));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic start_read(input logic [15:0] row, input logic [11:0] col,
    input logic [12:0] len);
    @(posedge SYS_CLK);
    REQ_ROW <= row;
    REQ_COL <= col;
    REQ_LEN <= len;
    REQ_VALID <= 1'b1;
    @(negedge SYS_CLK);
    for (int w = 0; w < 100 && REQ_READY !== 1'b1; w++) @(negedge SYS_CLK);
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b0;
  endtask : start_read
  task automatic finish_read(input logic [15:0] row, input logic [11:0] col, input int n_exp);
    logic [11:0] c;
    int n;
    c = col;
    n = 0;
    for (int w = 0; w < 20000 && RD_DONE !== 1'b1; w++) begin
      @(negedge SYS_CLK);
      if (RD_VALID === 1'b1) begin
        check("byte", row[7:0] ^ row[15:8] ^ c[7:0] ^ {4'h0, c[11:8]}, RD_DATA);
        c++;
        n++;
      end
    end
    check("count", n_exp[15:0], n[15:0]);
    repeat (2) @(negedge SYS_CLK);
    check("deselect", 16'h0001, {15'h0000, CHIP_SEL_N});
  endtask : finish_read
  task automatic t_idle();
    @(negedge SYS_CLK);
    check("idle select", 16'h0001, {15'h0000, CHIP_SEL_N});
    check("protect", 16'h0000, {15'h0000, WRITE_PROT_N});
  endtask : t_idle
  task automatic t_basic();
    start_read(16'h1234, 12'h000, 13'h0004);
    finish_read(16'h1234, 12'h000, 4);
  endtask : t_basic
  task automatic t_spare();
    start_read(16'hFFFF, 12'h7FE, 13'h0004);
    finish_read(16'hFFFF, 12'h7FE, 4);
  endtask : t_spare
  task automatic t_page_end();
    start_read(16'h0040, 12'h83E, 13'h0005);
    finish_read(16'h0040, 12'h83E, 2);
  endtask : t_page_end
  task automatic t_zero_len();
    start_read(16'h00A5, 12'h321, 13'h0000);
    finish_read(16'h00A5, 12'h321, 1);
  endtask : t_zero_len
  task automatic t_slow();
    busy_ns <= 16'h07D0;
    start_read(16'h8001, 12'h010, 13'h0002);
    repeat (150) @(negedge SYS_CLK);
    check("busy line", 16'h0000, {15'h0000, READY_BUSY_N});
    check("no read strobe", 16'h0001, {15'h0000, READ_STROBE_N});
    finish_read(16'h8001, 12'h010, 2);
  endtask : t_slow
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    SRST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    t_idle();
    t_basic();
    t_spare();
    t_page_end();
    t_zero_len();
    t_slow();
    summarize();
  end
endmodule : test_nand_flash_bus_interface
